//--- rcs_host.sv
`timescale 1ns/10ps
module rcs_host
(
   input  wire logic            clk_i,
   input  wire logic            ack_i,
   input  wire logic [31:0]     dat_i,
   output rcs_pkg::rcs_wb_req_s req_o
);
   import rcs_pkg::*;
   logic hung = 1'b0;
   initial req_o = '0;
   // One classic cycle, held until ack or for at most 100 clocks
   task automatic xfer(input logic we, input logic [7:0] idx,
                       input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      req_o <= '{1'b1, 1'b1, we, {idx, 2'h0}, 4'hf, {24'h0, d}};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_i !== 1'b1 && n < 100);
      if (n == 100)
         hung = 1'b1;
      q = dat_i[7:0];
      req_o <= '0;
      @(posedge clk_i);
   endtask
endmodule

//--- rcs_pkg.sv
package rcs_pkg;

   typedef enum logic [1:0] {
      RCS_IDLE,
      RCS_RUN,
      RCS_HALT
   } rcs_seq_e;

   // Drive levels in percent, 0 to 100
   typedef struct packed {
      logic [6:0] r;
      logic [6:0] g;
      logic [6:0] b;
   } rcs_rgb_s;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [9:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } rcs_wb_req_s;

   typedef struct packed {
      logic       ext_en;
      logic [6:0] cnt;
      logic       out;
   } rcs_pwm_state_s;

endpackage

//--- rcs_pwm.sv
`timescale 1ns/10ps
`include "rcs_regs.svh"

module rcs_pwm
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [6:0] duty_i,
   input  wire logic       gate_en_i,
   input  wire logic       ext_dim_i,
   output logic            pwm_o
);
   import rcs_pkg::*;

   rcs_pwm_state_s q;
   rcs_pwm_state_s d;

   always_comb
   begin
      d = q;
      if (q.cnt == `RCS_PWM_PERIOD - 7'd1)
      begin
         d.cnt = 7'd0;
      end
      else
      begin
         d.cnt = q.cnt + 7'd1;
      end
      d.ext_en = !gate_en_i || ext_dim_i;
      // Outside dimming gates the internal duty
      d.out = (q.cnt < duty_i) && q.ext_en;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign pwm_o = q.out;

endmodule

//--- rcs_regs.svh
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// Register indices, byte address is four times the index
`define RCS_IDX_CTRL      8'h11
`define RCS_IDX_CMD_FIRST 8'h50
`define RCS_IDX_CMD_LAST  8'h5f
`define RCS_IDX_XDIM      8'h18
`define RCS_IDX_STAT      8'h19

// Control register fields
`define RCS_CTRL_RUN      2
`define RCS_CTRL_LOOP     1
`define RCS_CTRL_CURVE    0
`define RCS_CTRL_RST      8'h00

// External dim control fields
`define RCS_XDIM_RED      2
`define RCS_XDIM_GREEN    1
`define RCS_XDIM_BLUE     0
`define RCS_XDIM_RST      8'h00

// Status register fields
`define RCS_STAT_RUNNING  0
`define RCS_STAT_HALTED   1
`define RCS_STAT_IDX_LO   2

// Timing and command count
`define RCS_CLK_PERIOD_NS 25
`define RCS_TICK_NS       1000000
`define RCS_PWM_PERIOD    7'd100
`define RCS_CMD_COUNT     8

`endif

//--- rcs_sequencer.sv
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "rcs_regs.svh"

module rcs_sequencer
#(
   parameter int TICK_CYCLES = `RCS_TICK_NS / `RCS_CLK_PERIOD_NS
)
(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire rcs_pkg::rcs_wb_req_s wb_req_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic                external_dim_input_i,
   output logic                     led_red_o,
   output logic                     led_green_o,
   output logic                     led_blue_o
);
   import rcs_pkg::*;

   typedef struct packed {
      logic [15:0] div;
      logic        ack;
      logic [31:0] rdat;
      logic [7:0]  ctrl;
      logic [7:0]  xdim;
      logic [15:0][7:0] cmd;
      logic        run_prev;
      rcs_seq_e    seq;
      logic [2:0]  idx;
      logic [11:0] el;
      logic [11:0] dwell;
      logic [11:0] fade;
      rcs_rgb_s    start;
      rcs_rgb_s    tgt;
      rcs_rgb_s    cur;
   } rcs_state_s;

   rcs_state_s q;
   rcs_state_s d;

   // Code to percent for the selected curve
   function automatic logic [6:0] level_pct(input logic [2:0] code,
                                            input logic curve);
      logic [6:0] v;
      v = 7'd0;
      case ({curve, code})
         4'h0: v = 7'd0;
         4'h1: v = 7'd7;
         4'h2: v = 7'd14;
         4'h3: v = 7'd21;
         4'h4: v = 7'd32;
         4'h5: v = 7'd46;
         4'h6: v = 7'd71;
         4'h7: v = 7'd100;
         4'h8: v = 7'd0;
         4'h9: v = 7'd1;
         4'ha: v = 7'd2;
         4'hb: v = 7'd4;
         4'hc: v = 7'd10;
         4'hd: v = 7'd21;
         4'he: v = 7'd46;
         default: v = 7'd100;
      endcase
      return v;
   endfunction

   // Dwell code to milliseconds
   function automatic logic [11:0] dwell_ms(input logic [3:0] code);
      logic [11:0] v;
      v = 12'd0;
      case (code)
         4'h0: v = 12'd197;
         4'h1: v = 12'd393;
         4'h2: v = 12'd590;
         4'h3: v = 12'd786;
         4'h4: v = 12'd983;
         4'h5: v = 12'd1180;
         4'h6: v = 12'd1376;
         4'h7: v = 12'd1573;
         4'h8: v = 12'd1769;
         4'h9: v = 12'd1966;
         4'ha: v = 12'd2163;
         4'hb: v = 12'd2359;
         4'hc: v = 12'd2556;
         4'hd: v = 12'd2753;
         4'he: v = 12'd2949;
         default: v = 12'd3146;
      endcase
      return v;
   endfunction

   // Fade code to milliseconds
   function automatic logic [11:0] fade_ms(input logic [2:0] code);
      logic [11:0] v;
      v = 12'd0;
      case (code)
         3'h0: v = 12'd0;
         3'h1: v = 12'd55;
         3'h2: v = 12'd110;
         3'h3: v = 12'd221;
         3'h4: v = 12'd442;
         3'h5: v = 12'd885;
         3'h6: v = 12'd1770;
         default: v = 12'd3539;
      endcase
      return v;
   endfunction

   // Linear, monotonic step from start toward target
   function automatic logic [6:0] ramp(input logic [6:0] s,
                                       input logic [6:0] t,
                                       input logic [11:0] el,
                                       input logic [11:0] len);
      logic [18:0] part;
      logic [6:0]  r;
      part = 19'd0;
      r = t;
      if (el < len)
      begin
         if (t >= s)
         begin
            part = ({12'd0, t - s} * {7'd0, el}) / {7'd0, len};
            r = s + part[6:0];
         end
         else
         begin
            part = ({12'd0, s - t} * {7'd0, el}) / {7'd0, len};
            r = s - part[6:0];
         end
      end
      return r;
   endfunction

   function automatic logic cmd_empty(input logic [15:0][7:0] c,
                                      input logic [2:0] i);
      return {c[{i, 1'b0}], c[{i, 1'b1}]} == 16'h0000;
   endfunction

   logic        tick;
   logic        access;
   logic [7:0]  widx;
   logic        run;
   logic        load;
   logic [2:0]  load_idx;
   logic [15:0] word;
   logic [2:0]  nxt;

   always_comb
   begin
      d = q;
      load = 1'b0;
      load_idx = 3'd0;
      word = 16'h0000;
      nxt = q.idx + 3'd1;
      widx = wb_req_i.adr[9:2];
      access = wb_req_i.cyc && wb_req_i.stb && !q.ack;

      tick = (q.div == 16'(TICK_CYCLES - 1));
      d.div = tick ? 16'h0000 : q.div + 16'h0001;

      // Bus slave, answer one cycle after the request
      d.ack = access;
      d.rdat = 32'h0000_0000;
      if (access && !wb_req_i.we)
      begin
         if (widx == `RCS_IDX_CTRL)
         begin
            d.rdat[7:0] = q.ctrl;
         end
         else if (widx == `RCS_IDX_XDIM)
         begin
            d.rdat[7:0] = q.xdim;
         end
         else if (widx == `RCS_IDX_STAT)
         begin
            d.rdat[`RCS_STAT_RUNNING] = (q.seq == RCS_RUN);
            d.rdat[`RCS_STAT_HALTED] = (q.seq == RCS_HALT);
            d.rdat[`RCS_STAT_IDX_LO +: 3] = q.idx;
         end
         else if (widx >= `RCS_IDX_CMD_FIRST && widx <= `RCS_IDX_CMD_LAST)
         begin
            d.rdat[7:0] = q.cmd[widx[3:0]];
         end
      end
      if (access && wb_req_i.we && wb_req_i.sel[0])
      begin
         if (widx == `RCS_IDX_CTRL)
         begin
            d.ctrl = {5'd0, wb_req_i.dat[2:0]};
         end
         else if (widx == `RCS_IDX_XDIM)
         begin
            d.xdim = {5'd0, wb_req_i.dat[2:0]};
         end
         else if (widx >= `RCS_IDX_CMD_FIRST && widx <= `RCS_IDX_CMD_LAST)
         begin
            d.cmd[widx[3:0]] = wb_req_i.dat[7:0];
         end
      end

      // Sequencer
      run = q.ctrl[`RCS_CTRL_RUN];
      d.run_prev = run;
      if (!run)
      begin
         d.seq = RCS_IDLE;
         d.idx = 3'd0;
         d.cur = '0;
      end
      else
      begin
         case (q.seq)
            RCS_IDLE:
            begin
               load = !q.run_prev;
               load_idx = 3'd0;
            end
            RCS_RUN:
            begin
               d.cur.r = ramp(q.start.r, q.tgt.r, q.el, q.fade);
               d.cur.g = ramp(q.start.g, q.tgt.g, q.el, q.fade);
               d.cur.b = ramp(q.start.b, q.tgt.b, q.el, q.fade);
               if (tick)
               begin
                  d.el = q.el + 12'd1;
                  if (q.el + 12'd1 >= q.dwell)
                  begin
                     if (q.idx == 3'd7 || cmd_empty(q.cmd, nxt))
                     begin
                        if (q.ctrl[`RCS_CTRL_LOOP])
                        begin
                           load = 1'b1;
                           load_idx = 3'd0;
                        end
                        else
                        begin
                           d.seq = RCS_HALT;
                           d.cur = q.tgt;
                        end
                     end
                     else
                     begin
                        load = 1'b1;
                        load_idx = nxt;
                     end
                  end
               end
            end
            RCS_HALT:
            begin
               d.cur = q.cur;
            end
            default:
            begin
               d.seq = RCS_IDLE;
            end
         endcase
      end

      if (load)
      begin
         word = {q.cmd[{load_idx, 1'b0}], q.cmd[{load_idx, 1'b1}]};
         d.idx = load_idx;
         d.el = 12'd0;
         d.start = q.cur;
         d.tgt.r = level_pct(word[15:13], q.ctrl[`RCS_CTRL_CURVE]);
         d.tgt.g = level_pct(word[12:10], q.ctrl[`RCS_CTRL_CURVE]);
         d.tgt.b = level_pct(word[5:3], q.ctrl[`RCS_CTRL_CURVE]);
         d.dwell = dwell_ms(word[9:6]);
         d.fade = fade_ms(word[2:0]);
         d.seq = (word == 16'h0000) ? RCS_HALT : RCS_RUN;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.ctrl <= `RCS_CTRL_RST;
         q.xdim <= `RCS_XDIM_RST;
         q.seq <= RCS_IDLE;
      end
      else
      begin
         q <= d;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;

   rcs_pwm u_pwm_red
   (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .duty_i    (q.cur.r),
      .gate_en_i (q.xdim[`RCS_XDIM_RED]),
      .ext_dim_i (external_dim_input_i),
      .pwm_o     (led_red_o)
   );

   rcs_pwm u_pwm_green
   (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .duty_i    (q.cur.g),
      .gate_en_i (q.xdim[`RCS_XDIM_GREEN]),
      .ext_dim_i (external_dim_input_i),
      .pwm_o     (led_green_o)
   );

   rcs_pwm u_pwm_blue
   (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .duty_i    (q.cur.b),
      .gate_en_i (q.xdim[`RCS_XDIM_BLUE]),
      .ext_dim_i (external_dim_input_i),
      .pwm_o     (led_blue_o)
   );

endmodule

//--- rcs_sequencer_bench.sv
`timescale 1ns/10ps
module rcs_sequencer_bench;
   import rcs_pkg::*;
   localparam int TK = 40;
   localparam int DW = 197 * TK;
   localparam int DL = 393 * TK - 2500;
   localparam logic [6:0] C0 [8] = '{7'h00, 7'h07, 7'h0e, 7'h15,
                                     7'h20, 7'h2e, 7'h47, 7'h64};
   localparam logic [6:0] C1 [8] = '{7'h00, 7'h01, 7'h02, 7'h04,
                                     7'h0a, 7'h15, 7'h2e, 7'h64};
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ext_i = 1'b1;
   rcs_wb_req_s req;
   logic [31:0] rdat;
   logic        ack, led_r, led_g, led_b;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cyc_n = 0;
   logic        hung_q = 1'b0;
   logic [8:0]  expq[$];
   logic [8:0]  e;
   logic [7:0]  rnd = 8'h29;
   logic [2:0]  r1, g1, b1, r2, g2, b2;

   rcs_sequencer #(.TICK_CYCLES(TK)) i_dut
   (
      .clk_i                (clk_i),
      .rst_i                (rst_i),
      .wb_req_i             (req),
      .wb_dat_o             (rdat),
      .wb_ack_o             (ack),
      .external_dim_input_i (ext_i),
      .led_red_o            (led_r),
      .led_green_o          (led_g),
      .led_blue_o           (led_b)
   );
   rcs_host i_host
   (
      .clk_i (clk_i),
      .ack_i (ack),
      .dat_i (rdat),
      .req_o (req)
   );

   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cyc_n <= cyc_n + 1;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [6:0] pct(input logic c, input logic [2:0] k);
      pct = c ? C1[k] : C0[k];
   endfunction

   task close_out;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x)
      begin
         fail_count++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, x, g);
      end
   endtask
   task wr(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] q;
      i_host.xfer(1'b1, i, d, q);
   endtask
   task rd(input logic [7:0] i, input logic [7:0] x);
      logic [7:0] q;
      expq.push_back({1'b1, x});
      i_host.xfer(1'b0, i, 8'h00, q);
   endtask
   // Poll status until masked value seen, then check elapsed time
   task wait_st(input logic [7:0] m, input logic [7:0] v, input int dw);
      logic [7:0] q;
      int         t0, k;
      t0 = cyc_n;
      k = 0;
      do
      begin
         expq.push_back(9'h000);
         i_host.xfer(1'b0, 8'h19, 8'h00, q);
         k++;
      end
      while ((q & m) !== v && k < dw / 2 && !i_host.hung);
      chk(32'h1, {31'h0, (cyc_n-t0 > dw-60) && (cyc_n-t0 < dw+60)});
      if ((q & m) !== v)
      begin
         fail_count++;
         $display("[ERR] t=%0t status exp=%h got=%h", $time, v, q & m);
      end
   endtask
   task chk_rgb(input logic c, input logic [2:0] kr, kg, kb);
      logic [31:0] r, g, b;
      r = 32'h0;
      g = 32'h0;
      b = 32'h0;
      repeat (100)
      begin
         @(posedge clk_i);
         r += {31'h0, led_r === 1'b1};
         g += {31'h0, led_g === 1'b1};
         b += {31'h0, led_b === 1'b1};
      end
      chk({25'h0, pct(c, kr)}, r);
      chk({25'h0, pct(c, kg)}, g);
      chk({25'h0, pct(c, kb)}, b);
   endtask

   always @(posedge clk_i)
   begin
      if (i_host.hung && !hung_q)
      begin
         fail_count++;
         $display("[ERR] t=%0t bus ack exp=%h got=%h", $time, 1'b1, 1'b0);
      end
      hung_q <= i_host.hung;
      if (ack === 1'b1 && req.we === 1'b0)
      begin
         e = expq.size() > 0 ? expq.pop_front() : 9'h1ff;
         if (e[8])
            chk({24'h0, e[7:0]}, rdat);
      end
   end

   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h11, 8'h00);
      rd(8'h18, 8'h00);
      wr(8'h20, 8'hff);
      rd(8'h20, 8'h00);
      rnd = lfsr(rnd);
      {g1, r1} = {rnd[5:3], rnd[2:0] | 3'h1};
      rnd = lfsr(rnd);
      {r2, b1} = rnd[5:0];
      rnd = lfsr(rnd);
      {b2, g2} = rnd[5:0];
      wr(8'h50, {r1, g1, 2'h0});
      wr(8'h51, {2'h0, b1, 3'h0});
      wr(8'h52, {r2, g2, 2'h0});
      wr(8'h53, {2'h0, b2, 3'h7});
      rd(8'h53, {2'h0, b2, 3'h7});
      $display("registers done");
      wr(8'h11, 8'h04);
      wait_st(8'h1c, 8'h04, DW);
      wait_st(8'h02, 8'h02, DW);
      chk_rgb(1'b0, r2, g2, b2);
      wr(8'h52, 8'h00);
      chk_rgb(1'b0, r2, g2, b2);
      $display("single run done");
      wr(8'h11, 8'h00);
      repeat (5) @(posedge clk_i);
      chk_rgb(1'b0, 3'h0, 3'h0, 3'h0);
      wr(8'h11, 8'h05);
      repeat (200) @(posedge clk_i);
      chk_rgb(1'b1, r1, g1, b1);
      wr(8'h18, 8'h04);
      ext_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk_rgb(1'b1, 3'h0, g1, b1);
      ext_i <= 1'b1;
      wr(8'h18, 8'h00);
      $display("curve and dim done");
      wr(8'h11, 8'h00);
      wr(8'h51, {2'h1, b1, 3'h1});
      wr(8'h11, 8'h06);
      repeat (2400) @(posedge clk_i);
      chk_rgb(1'b0, r1, g1, b1);
      wait_st(8'h1c, 8'h04, DL);
      wait_st(8'h1c, 8'h00, DW);
      rd(8'h19, 8'h01);
      wr(8'h11, 8'h00);
      $display("loop done");
      close_out();
   end
endmodule

//--- rcs_sequencer_sva.sv
`timescale 1ns/10ps
module rcs_sva
#(
   parameter int TICK_CYCLES = 40000
)
(
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire rcs_pkg::rcs_wb_req_s wb_req_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   input wire logic                 external_dim_input_i,
   input wire logic                 led_red_o,
   input wire logic                 led_green_o,
   input wire logic                 led_blue_o
);
   import rcs_pkg::*;
   logic [2:0] en_q;
   logic       run_q;
   logic       req_w;
   logic       wr_w;
   assign req_w = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   assign wr_w  = req_w && wb_req_i.we && wb_req_i.sel[0];
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en_q  <= 3'h0;
         run_q <= 1'b0;
      end
      else if (wr_w && wb_req_i.adr == 10'h060)
         en_q <= wb_req_i.dat[2:0];
      else if (wr_w && wb_req_i.adr == 10'h044)
         run_q <= wb_req_i.dat[2];
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_next; req_w |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_ack_cause; wb_ack_o |-> $past(req_w); endproperty
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   property p_dat_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
   property p_dim_red;
      (en_q[2] && !external_dim_input_i) [*3] |-> !led_red_o;
   endproperty
   property p_dim_green;
      (en_q[1] && !external_dim_input_i) [*3] |-> !led_green_o;
   endproperty
   property p_dim_blue;
      (en_q[0] && !external_dim_input_i) [*3] |-> !led_blue_o;
   endproperty
   property p_run_off;
      (!run_q) [*5] |-> !(led_red_o || led_green_o || led_blue_o);
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("ack late");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack too long");
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   a_dat_idle: assert property (p_dat_idle)
      else $error("read data outside ack");
   a_dat_upper: assert property (p_dat_upper)
      else $error("upper read bits set");
   a_dim_red: assert property (p_dim_red)
      else $error("red not dimmed");
   a_dim_green: assert property (p_dim_green)
      else $error("green not dimmed");
   a_dim_blue: assert property (p_dim_blue)
      else $error("blue not dimmed");
   a_run_off: assert property (p_run_off)
      else $error("led on while stopped");
   c_read: cover property (wb_ack_o && !wb_req_i.we);
   c_dim: cover property (en_q[2] && !external_dim_input_i);
   c_led: cover property ($rose(led_red_o));
endmodule

bind rcs_sequencer rcs_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva
(
   .clk_i                (clk_i),
   .rst_i                (rst_i),
   .wb_req_i             (wb_req_i),
   .wb_dat_o             (wb_dat_o),
   .wb_ack_o             (wb_ack_o),
   .external_dim_input_i (external_dim_input_i),
   .led_red_o            (led_red_o),
   .led_green_o          (led_green_o),
   .led_blue_o           (led_blue_o)
);
